// *** bench/clockgen_mode_ctrl_monitor.sv ***
// Concurrent checks on the mode and pin control ports
`timescale 1ns/100ps
`default_nettype none

module clockgen_mode_ctrl_monitor (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     resetn,
  // Watched inputs
  input  wire logic                     pdn_input_sel,
  input  wire logic                     spread_spectrum_enable,
  input  wire clockgen_pkg::pd_ctrl_t   power_ctrl,
  input  wire logic                     sync_low_input,
  input  wire logic                     pll_locked,
  input  wire logic                     sda_drive_low,
  // Watched outputs
  input  wire clockgen_pkg::gpio_pins_t general_pin,
  input  wire logic                     sda_in,
  input  wire logic                     scl_in,
  input  wire logic                     i2c_active,
  input  wire logic                     boot_done,
  input  wire logic                     nvm_read_enable,
  input  wire logic                     pll_auto_cal,
  input  wire logic                     spread_spectrum_active,
  input  wire logic                     numerator_step_up,
  input  wire logic                     numerator_step_down,
  input  wire logic [3:0]               channel_run,
  input  wire logic [3:0]               divider_release,
  input  wire clockgen_pkg::pd_out_t    power_out
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================
  // Assertions
  AST_BYPASS_PD:
    assert property (power_out.bypass_pd == power_out.channel_pd[3])
    else $error("bypass power-down differs from channel four");
  AST_GLOBAL_PD:
    assert property (power_ctrl.global_power_down [*2] |-> &power_out)
    else $error("global power-down left a block running");
  AST_LOCK_OUT:
    assert property (boot_done && !nvm_read_enable && $past(boot_done, 4) |->
      general_pin.drive[0] == $past(pll_locked, 3) && !general_pin.oe_n[0])
    else $error("lock output wrong");
  AST_FALLBACK_BOOT:
    assert property (boot_done && !nvm_read_enable |-> i2c_active && !pll_auto_cal)
    else $error("fall-back boot state wrong");
  AST_IDLE_LINES:
    assert property (!i2c_active |-> sda_in && scl_in)
    else $error("serial lines seen outside serial use");
  AST_PIN_INPUTS:
    assert property (boot_done && !i2c_active |-> general_pin.oe_n == 4'hF)
    else $error("pin mode drives a pin");
  AST_DATA_OE:
    assert property (!general_pin.oe_n[1] |->
      $past(sda_drive_low) && i2c_active && general_pin.oe_n[2])
    else $error("data pin driven without cause");
  AST_STEP_PULSE:
    assert property (numerator_step_up || numerator_step_down |=>
      !numerator_step_up && !numerator_step_down)
    else $error("step pulse too long");
  AST_SYNC_MUTE:
    assert property ((pdn_input_sel && !sync_low_input) [*5] |-> channel_run == 4'h0)
    else $error("outputs run while sync low");
  AST_SSC_FORCE:
    assert property ((spread_spectrum_enable && boot_done) [*4] |-> spread_spectrum_active)
    else $error("spread not forced on");

  // ==========================================
  // Coverage
  COV_FALLBACK: cover property (boot_done && i2c_active && !nvm_read_enable);
  COV_STEP_DOWN: cover property (numerator_step_down);
  COV_RELEASE: cover property (divider_release != 4'h0);
endmodule : clockgen_mode_ctrl_monitor

bind clockgen_mode_ctrl clockgen_mode_ctrl_monitor clockgen_mode_ctrl_monitor_inst (
  .core_clk, .resetn, .pdn_input_sel, .spread_spectrum_enable, .power_ctrl,
  .sync_low_input, .pll_locked, .sda_drive_low, .general_pin, .sda_in, .scl_in,
  .i2c_active, .boot_done, .nvm_read_enable, .pll_auto_cal, .spread_spectrum_active,
  .numerator_step_up, .numerator_step_down, .channel_run, .divider_release, .power_out);

`default_nettype wire

// *** bench/pin_board.sv ***
// Board and serial host model around the shared control pins
`timescale 1ns/100ps
`default_nettype none

module pin_board (
  // Device side of the shared pins
  input  wire clockgen_pkg::gpio_pins_t general_pin,
  // Levels the board or the serial host puts on each pin
  input  wire logic [3:0]               board_level,
  // Resolved wire levels
  output var  logic [3:0]               general_pin_in
);
  // ==========================================
  // Wire resolution
  // Device wins while it drives; a released data line reads the host or its pull-up
  always_comb
    for (int i = 0; i < 4; i++)
      general_pin_in[i] = general_pin.oe_n[i] ? board_level[i] : general_pin.drive[i];
endmodule : pin_board

`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the mode and pin control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
      $display("[ERR] %0t got %h want %h", $time, (g), (e)); \
    if ((g) !== (e)) \
      errors++; \
  end
`define W(c, n) for (k = 0; k < (n) && !(c); k++) tick(1);

module testbench;
  typedef struct packed {
    logic [5:0] stim;
    logic [3:0] exp;
    logic [6:0] addr;
  } boot_row_t;
  // Straps, stored mode, address bit; expected serial, read, calibrate, page
  localparam boot_row_t ROWS [7] = '{'{6'h00, 4'h6, 7'h68}, '{6'h28, 4'h7, 7'h68},
    '{6'h23, 4'hF, 7'h69}, '{6'h0A, 4'hE, 7'h68}, '{6'h13, 4'h8, 7'h68},
    '{6'h04, 4'h8, 7'h67}, '{6'h15, 4'h8, 7'h67}};

  logic core_clk, resetn, nvm_serial_enable, nvm_address_lsb, pdn_input_sel, chan_clk;
  logic spread_spectrum_enable, sync_low_input, pll_locked, sda_drive_low;
  logic [1:0] page_select_strap, reference_select_strap;
  logic [3:0] sync_enable, channel_low_voltage_detect, general_pin_in, board_level;
  logic [3:0] channel_clock, channel_run, divider_release, low_voltage_detect_out;
  logic [3:0] up_cnt, dn_cnt, rel, rel_cnt;
  clockgen_pkg::gpio_func_t gpio_one_func, gpio_four_func;
  clockgen_pkg::pd_ctrl_t   power_ctrl;
  clockgen_pkg::gpio_pins_t general_pin;
  clockgen_pkg::pd_out_t    power_out;
  logic sda_in, scl_in, i2c_active, boot_done, nvm_read_enable, nvm_page_one, pll_auto_cal;
  logic core_reset_n, spread_spectrum_active, numerator_step_up, numerator_step_down;
  logic bypass_run;
  logic [6:0] i2c_address;
  int errors = 0;
  int check_count = 0;
  int i, k;

  assign channel_clock = {4{chan_clk}};

  clockgen_mode_ctrl clockgen_mode_ctrl_inst (.core_clk, .resetn, .page_select_strap,
    .reference_select_strap, .nvm_serial_enable, .nvm_address_lsb, .pdn_input_sel,
    .spread_spectrum_enable, .gpio_one_func, .gpio_four_func, .sync_enable,
    .channel_low_voltage_detect, .power_ctrl, .sync_low_input, .general_pin_in,
    .general_pin, .pll_locked, .channel_clock, .sda_drive_low, .sda_in, .scl_in,
    .i2c_active, .i2c_address, .boot_done, .nvm_read_enable, .nvm_page_one, .pll_auto_cal,
    .core_reset_n, .spread_spectrum_active, .numerator_step_up, .numerator_step_down,
    .channel_run, .bypass_run, .divider_release, .power_out, .low_voltage_detect_out);

  pin_board pin_board_inst (.general_pin, .board_level, .general_pin_in);

  // ==========================================
  // Clocks and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Channel clock at 200 ns, phase unrelated to the core clock
  initial
  begin
    chan_clk = 1'b0;
    #7;
    forever #100 chan_clk = ~chan_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end

  // ==========================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  task automatic do_boot(input logic [5:0] s);
    {page_select_strap, reference_select_strap, nvm_serial_enable, nvm_address_lsb} = s;
    resetn = 1'b0;
    tick(20);
    resetn = 1'b1;
    `W(boot_done, 40)
    `CHK(boot_done, 1'b1)
  endtask : do_boot

  task automatic tally_and_finish();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // Main sequence
  initial
  begin
    {resetn, page_select_strap, reference_select_strap} = '0;
    {nvm_serial_enable, nvm_address_lsb, pdn_input_sel, spread_spectrum_enable} = '0;
    gpio_one_func = clockgen_pkg::FUNC_NONE;
    gpio_four_func = clockgen_pkg::FUNC_NONE;
    {power_ctrl, pll_locked, sda_drive_low, sync_low_input} = 17'h00001;
    sync_enable = 4'h5;
    channel_low_voltage_detect = 4'hA;
    board_level = 4'hF;
    tick(20);
    `CHK(core_reset_n, 1'b0)
    `CHK(general_pin.oe_n, 4'hF)
    for (i = 0; i < 7; i++)
    begin
      do_boot(ROWS[i].stim);
      `CHK(i2c_active, ROWS[i].exp[3])
      `CHK(nvm_read_enable, ROWS[i].exp[2])
      `CHK(pll_auto_cal, ROWS[i].exp[1])
      if (ROWS[i].exp[2])
        `CHK(nvm_page_one, ROWS[i].exp[0])
      `CHK(i2c_address, ROWS[i].addr)
    end
    // Pin mode: channel three enable is qualified over channel clocks
    do_boot(6'h00);
    `W(channel_run == 4'hF, 60)
    `CHK(channel_run, 4'hF)
    board_level = 4'hB;
    tick(12);
    `CHK(channel_run, 4'hF)
    `W(channel_run == 4'hB, 40)
    `CHK(channel_run, 4'hB)
    // Serial mode: spread starts on from the pin, pin four is global enable
    board_level = 4'hF;
    gpio_one_func = clockgen_pkg::FUNC_SSC;
    gpio_four_func = clockgen_pkg::FUNC_GLOBAL_OE;
    do_boot(6'h0A);
    tick(4);
    `CHK(spread_spectrum_active, 1'b1)
    board_level = 4'hE;
    tick(6);
    `CHK(spread_spectrum_active, 1'b0)
    board_level = 4'hF;
    tick(6);
    `CHK(spread_spectrum_active, 1'b0)
    spread_spectrum_enable = 1'b1;
    tick(6);
    `CHK(spread_spectrum_active, 1'b1)
    board_level = 4'h7;
    `W(channel_run == 4'h0, 40)
    `CHK(channel_run, 4'h0)
    `CHK(bypass_run, 1'b1)
    // Step pins, one at a time, each counted as pulses
    board_level = 4'h6;
    gpio_one_func = clockgen_pkg::FUNC_STEP_UP;
    gpio_four_func = clockgen_pkg::FUNC_STEP_DOWN;
    tick(4);
    for (i = 0; i < 2; i++)
    begin
      board_level = i ? 4'hE : 4'h7;
      {up_cnt, dn_cnt} = '0;
      repeat (10)
      begin
        tick(1);
        up_cnt += {3'h0, numerator_step_up};
        dn_cnt += {3'h0, numerator_step_down};
      end
      `CHK(up_cnt, (i ? 4'h0 : 4'h1))
      `CHK(dn_cnt, (i ? 4'h1 : 4'h0))
      board_level = 4'h6;
      tick(4);
    end
    // Strap and stored mode changes after boot are ignored
    nvm_serial_enable = 1'b0;
    page_select_strap = 2'h2;
    tick(20);
    `CHK(i2c_active, 1'b1)
    `CHK(nvm_page_one, 1'b0)
    sda_drive_low = 1'b1;
    tick(2);
    `CHK(general_pin.oe_n[1], 1'b0)
    tick(3);
    `CHK(sda_in, 1'b0)
    sda_drive_low = 1'b0;
    board_level = 4'h2;
    tick(5);
    `CHK(scl_in, 1'b0)
    // Fall-back: lock output, sync, power-down
    board_level = 4'hF;
    do_boot(6'h15);
    `CHK(core_reset_n, 1'b1)
    pll_locked = 1'b1;
    `W(general_pin.drive[0], 8)
    `CHK(general_pin.drive[0], 1'b1)
    `CHK(general_pin.oe_n[0], 1'b0)
    `CHK(general_pin.oe_n[3], 1'b1)
    pll_locked = 1'b0;
    tick(5);
    `CHK(general_pin.drive[0], 1'b0)
    pdn_input_sel = 1'b1;
    sync_low_input = 1'b0;
    tick(6);
    `CHK(channel_run, 4'h0)
    `CHK(core_reset_n, 1'b1)
    sync_low_input = 1'b1;
    {rel, rel_cnt} = '0;
    repeat (8)
    begin
      tick(1);
      rel |= divider_release;
      rel_cnt += {3'h0, divider_release != 4'h0};
    end
    `CHK(rel, 4'h5)
    `CHK(rel_cnt, 4'h1)
    power_ctrl.channel_four_pd_bit = 1'b1;
    tick(3);
    `CHK(power_out, 14'h0011)
    power_ctrl = '0;
    power_ctrl.global_power_down = 1'b1;
    tick(3);
    `CHK(power_out, 14'h3FFF)
    `CHK(low_voltage_detect_out, 4'hA)
    pdn_input_sel = 1'b0;
    sync_low_input = 1'b0;
    `W(!core_reset_n, 8)
    `CHK(core_reset_n, 1'b0)
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire

// *** core/clockgen_mode_ctrl.sv ***
// Mode selection and control-pin logic of the clock generator
`timescale 1ns/100ps
`default_nettype none

module clockgen_mode_ctrl (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // Tri-level straps
  input  wire logic [1:0]              page_select_strap,
  input  wire logic [1:0]              reference_select_strap,
  // Stored boot image
  input  wire logic                    nvm_serial_enable,
  input  wire logic                    nvm_address_lsb,
  // Configuration bits
  input  wire logic                    pdn_input_sel,
  input  wire logic                    spread_spectrum_enable,
  input  wire clockgen_pkg::gpio_func_t gpio_one_func,
  input  wire clockgen_pkg::gpio_func_t gpio_four_func,
  input  wire logic [3:0]              sync_enable,
  input  wire logic [3:0]              channel_low_voltage_detect,
  input  wire clockgen_pkg::pd_ctrl_t  power_ctrl,
  // Device pins
  input  wire logic                    sync_low_input,
  input  wire logic [3:0]              general_pin_in,
  output var  clockgen_pkg::gpio_pins_t general_pin,
  // Analog status and channel clocks
  input  wire logic                    pll_locked,
  input  wire logic [3:0]              channel_clock,
  // Serial engine side
  input  wire logic                    sda_drive_low,
  output var  logic                    sda_in,
  output var  logic                    scl_in,
  output var  logic                    i2c_active,
  output var  logic [6:0]              i2c_address,
  // Boot control
  output var  logic                    boot_done,
  output var  logic                    nvm_read_enable,
  output var  logic                    nvm_page_one,
  output var  logic                    pll_auto_cal,
  // Core control
  output var  logic                    core_reset_n,
  output var  logic                    spread_spectrum_active,
  output var  logic                    numerator_step_up,
  output var  logic                    numerator_step_down,
  output var  logic [3:0]              channel_run,
  output var  logic                    bypass_run,
  output var  logic [3:0]              divider_release,
  output var  clockgen_pkg::pd_out_t   power_out,
  output var  logic [3:0]              low_voltage_detect_out
);

  // ==========================================
  // Pin synchronisers
  localparam int NSYNC = 14;

  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] raw_in;

  assign raw_in = {pll_locked, reference_select_strap, page_select_strap,
                   channel_clock, general_pin_in, sync_low_input};

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic       pdn_s;
  logic [3:0] pin_s;
  logic [3:0] chan_s;
  logic [1:0] page_s;
  logic [1:0] ref_s;
  logic       lock_s;

  assign pdn_s  = sync_b[0];
  assign pin_s  = sync_b[4:1];
  assign chan_s = sync_b[8:5];
  assign page_s = sync_b[10:9];
  assign ref_s  = sync_b[12:11];
  assign lock_s = sync_b[13];

  // ==========================================
  // Boot sequence: straps sampled once after release
  clockgen_pkg::boot_state_t state;
  clockgen_pkg::mode_t       mode;
  logic [3:0]                settle;
  logic                      ref_float;
  logic                      page_high;
  logic                      addr_lsb;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state  <= clockgen_pkg::BOOT_WAIT;
      settle <= 4'h0;
    end
    else
    begin
      case (state)
        clockgen_pkg::BOOT_WAIT:
        begin
          if (settle == clockgen_pkg::STRAP_SETTLE_CYCLES - 4'h1)
            state <= clockgen_pkg::BOOT_SAMPLE;
          else
            settle <= settle + 4'h1;
        end
        clockgen_pkg::BOOT_SAMPLE:
          state <= clockgen_pkg::BOOT_RUN;
        clockgen_pkg::BOOT_RUN:
          state <= clockgen_pkg::BOOT_RUN;
        default:
          state <= clockgen_pkg::BOOT_WAIT;
      endcase
    end
  end

  // Stored mode is only looked at here, so later writes wait for a reboot
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode      <= clockgen_pkg::MODE_NONE;
      ref_float <= 1'b0;
      page_high <= 1'b0;
      addr_lsb  <= 1'b0;
    end
    else if (state == clockgen_pkg::BOOT_SAMPLE)
    begin
      ref_float <= (ref_s == clockgen_pkg::STRAP_MID);
      page_high <= (page_s == clockgen_pkg::STRAP_HIGH);
      addr_lsb  <= nvm_address_lsb;
      if (page_s == clockgen_pkg::STRAP_MID ||
          ref_s == clockgen_pkg::STRAP_MID)
        mode <= clockgen_pkg::MODE_FALLBACK;
      else if (nvm_serial_enable)
        mode <= clockgen_pkg::MODE_SERIAL;
      else
        mode <= clockgen_pkg::MODE_PIN;
    end
  end

  logic fallback;
  logic serial_on;
  logic pin_mode;

  assign fallback  = (mode == clockgen_pkg::MODE_FALLBACK);
  assign pin_mode  = (mode == clockgen_pkg::MODE_PIN);
  assign serial_on = fallback | (mode == clockgen_pkg::MODE_SERIAL);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      boot_done       <= 1'b0;
      nvm_read_enable <= 1'b0;
      nvm_page_one    <= 1'b0;
      pll_auto_cal    <= 1'b0;
      i2c_active      <= 1'b0;
      i2c_address     <= clockgen_pkg::ADDR_NORMAL;
    end
    else
    begin
      boot_done       <= (mode != clockgen_pkg::MODE_NONE);
      nvm_read_enable <= (mode != clockgen_pkg::MODE_NONE) & ~fallback;
      nvm_page_one    <= page_high;
      pll_auto_cal    <= (mode != clockgen_pkg::MODE_NONE) & ~fallback;
      i2c_active      <= serial_on;
      if (fallback && ref_float)
        i2c_address <= clockgen_pkg::ADDR_FALLBACK;
      else
        i2c_address <= {clockgen_pkg::ADDR_NORMAL[6:1], addr_lsb & ~fallback};
    end
  end

  // ==========================================
  // Pin function assignment
  clockgen_pkg::gpio_func_t func_one;
  clockgen_pkg::gpio_func_t func_four;

  always_comb
  begin
    func_one  = clockgen_pkg::FUNC_NONE;
    func_four = clockgen_pkg::FUNC_NONE;
    if (fallback)
    begin
      func_one = clockgen_pkg::FUNC_LOCK;
      if (gpio_four_func != clockgen_pkg::FUNC_LOCK)
        func_four = gpio_four_func;
    end
    else if (mode == clockgen_pkg::MODE_SERIAL)
    begin
      func_one  = gpio_one_func;
      func_four = gpio_four_func;
    end
  end

  // Level of a GPIO function, or a default when no pin carries it
  function automatic logic func_level(
    input clockgen_pkg::gpio_func_t f,
    input clockgen_pkg::gpio_func_t f1,
    input clockgen_pkg::gpio_func_t f4,
    input logic [3:0]               pins,
    input logic                     dflt
  );
    logic lvl;
    lvl = dflt;
    if (f1 == f)
      lvl = pins[0];
    else if (f4 == f)
      lvl = pins[3];
    return lvl;
  endfunction : func_level

  function automatic logic func_used(
    input clockgen_pkg::gpio_func_t f,
    input clockgen_pkg::gpio_func_t f1,
    input clockgen_pkg::gpio_func_t f4
  );
    return (f1 == f) | (f4 == f);
  endfunction : func_used

  // ==========================================
  // Pin drivers; serial and GPIO roles never overlap
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      general_pin.drive <= 4'h0;
      general_pin.oe_n  <= 4'hF;
    end
    else
    begin
      general_pin.drive[0] <= lock_s;
      general_pin.oe_n[0]  <= (func_one != clockgen_pkg::FUNC_LOCK);
      general_pin.drive[3] <= lock_s;
      general_pin.oe_n[3]  <= (func_four != clockgen_pkg::FUNC_LOCK);
      general_pin.drive[1] <= 1'b0;
      general_pin.oe_n[1]  <= ~(serial_on & sda_drive_low);
      general_pin.drive[2] <= 1'b0;
      general_pin.oe_n[2]  <= 1'b1;
    end
  end

  // Serial engine sees idle-high lines outside the serial modes
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_in <= 1'b1;
      scl_in <= 1'b1;
    end
    else
    begin
      sda_in <= serial_on ? pin_s[1] : 1'b1;
      scl_in <= serial_on ? pin_s[2] : 1'b1;
    end
  end

  // ==========================================
  // Spread spectrum: pin may only switch it off
  logic ssc_pin_on;
  logic ssc_used;

  assign ssc_used = func_used(clockgen_pkg::FUNC_SSC, func_one, func_four);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ssc_pin_on <= clockgen_pkg::SSC_PIN_RESET;
    else if (ssc_used && !func_level(clockgen_pkg::FUNC_SSC, func_one,
                                     func_four, pin_s, 1'b1))
      ssc_pin_on <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      spread_spectrum_active <= 1'b0;
    else
      spread_spectrum_active <= spread_spectrum_enable |
                                (ssc_used & ssc_pin_on);
  end

  // ==========================================
  // Frequency stepping on pin rising edges
  logic up_lvl;
  logic down_lvl;
  logic up_prev;
  logic down_prev;

  assign up_lvl   = func_level(clockgen_pkg::FUNC_STEP_UP, func_one,
                               func_four, pin_s, 1'b0);
  assign down_lvl = func_level(clockgen_pkg::FUNC_STEP_DOWN, func_one,
                               func_four, pin_s, 1'b0);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      up_prev             <= 1'b0;
      down_prev           <= 1'b0;
      numerator_step_up   <= 1'b0;
      numerator_step_down <= 1'b0;
    end
    else
    begin
      up_prev             <= up_lvl;
      down_prev           <= down_lvl;
      numerator_step_up   <= up_lvl & ~up_prev;
      numerator_step_down <= down_lvl & ~down_prev;
    end
  end

  // ==========================================
  // Power-down and sync pin roles
  logic sync_prev;
  logic mute;

  assign mute = pdn_input_sel & ~pdn_s;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_reset_n    <= 1'b0;
      sync_prev       <= 1'b0;
      divider_release <= 4'h0;
    end
    else
    begin
      core_reset_n    <= pdn_input_sel | pdn_s;
      sync_prev       <= pdn_s;
      divider_release <= {4{pdn_input_sel & pdn_s & ~sync_prev}}
                         & sync_enable;
    end
  end

  // ==========================================
  // Individual channel enables, qualified per channel clock
  logic [3:0] oe_req;
  logic [3:0] oe_ok;

  assign oe_req = pin_mode ? pin_s : 4'hF;

  for (genvar i = 0; i < 4; i++)
  begin : g_oe
    oe_qualify #(
      .EDGES (clockgen_pkg::OE_QUAL_EDGES)
    ) u_oe (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .level     (oe_req[i]),
      .chan_clk  (chan_s[i]),
      .qualified (oe_ok[i])
    );
  end

  // ==========================================
  // Power management and channel gating
  logic [3:0] ch_bits;
  logic [3:0] ch_pd;
  logic       global_oe;

  assign ch_bits   = {power_ctrl.channel_four_pd_bit,
                      power_ctrl.channel_three_power_down,
                      power_ctrl.channel_two_power_down,
                      power_ctrl.channel_one_power_down};
  assign ch_pd     = ch_bits | {4{power_ctrl.global_power_down}};
  assign global_oe = func_level(clockgen_pkg::FUNC_GLOBAL_OE, func_one,
                                func_four, pin_s, 1'b1);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      power_out              <= '1;
      channel_run            <= 4'h0;
      bypass_run             <= 1'b0;
      low_voltage_detect_out <= 4'h0;
    end
    else
    begin
      power_out.pll_block_pd <= power_ctrl.pll_block_pd |
                                {9{power_ctrl.global_power_down}};
      power_out.channel_pd   <= ch_pd;
      power_out.bypass_pd    <= ch_pd[3];
      channel_run            <= ~ch_pd & oe_ok & {4{global_oe & ~mute}};
      bypass_run             <= ~ch_pd[3] & boot_done;
      low_voltage_detect_out <= channel_low_voltage_detect;
    end
  end

endmodule : clockgen_mode_ctrl

`default_nettype wire

// *** core/oe_qualify.sv ***
// Output-enable level qualifier counting output clock edges
`timescale 1ns/100ps
`default_nettype none

module oe_qualify #(
  parameter int EDGES = clockgen_pkg::OE_QUAL_EDGES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Requested level and synchronised channel clock
  input  wire logic level,
  input  wire logic chan_clk,
  // Qualified enable
  output var  logic qualified
);

  // ==========================================
  // Edge detection on the sampled channel clock
  logic       chan_prev;
  logic [2:0] count;
  logic       chan_rise;

  assign chan_rise = chan_clk & ~chan_prev;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      chan_prev <= 1'b0;
    else
      chan_prev <= chan_clk;
  end

  // ==========================================
  // A level must hold across EDGES clock edges before it counts
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count     <= 3'h0;
      qualified <= 1'b1;
    end
    else if (level == qualified)
      count <= 3'h0;
    else if (chan_rise)
    begin
      if (count == 3'(EDGES - 1))
      begin
        qualified <= level;
        count     <= 3'h0;
      end
      else
        count <= count + 3'h1;
    end
  end

endmodule : oe_qualify

`default_nettype wire

// *** inc/clockgen_pkg.sv ***
// Constants and types for the clock generator mode and pin control
// Behaviour
// - Page strap sampled once: low page0, high page1
// - Mid page strap loads default, serial on
// - Shared pins serve serial or GPIO, never both
// - Power-down pin resets core, optionally sync input
// - Sync low mutes differential outputs, high runs
// - Spread register bit set forces spread on
// - Spread pin only starts high then disables
// - Step pins move modulator numerator up/down
// - Global enable gates four channels, not bypass
// - Lock pin drives 0 unlocked, 1 locked
// - Per-block power-down bits plus global power-down
// - Bypass output follows channel four power-down
// - Stored mode changes act only after reboot
// - Either strap floating enters fall-back mode
// - Fall-back skips memory read, boots defaults
// - Fall-back: pin four input, pin one output
// - Fall-back keeps serial on, no auto calibration
// - Pin mode: four pins are channel enables
// - Serial mode: pins two, three serial; rest GPIO
// - Address 67h fall-back floating ref, else 68h, or 69h with address bit set outside fall-back
// - Channel enables qualified over four output clocks
// - Sync rising releases enabled dividers together
`default_nettype none

package clockgen_pkg;

  // ==========================================
  // Strap level codes from the tri-level detector
  localparam logic [1:0] STRAP_LOW  = 2'h0;
  localparam logic [1:0] STRAP_MID  = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // ==========================================
  // Boot and qualification counts
  localparam logic [3:0] STRAP_SETTLE_CYCLES = 4'h8;
  localparam int         OE_QUAL_EDGES       = 4;

  // ==========================================
  // Serial target addresses
  localparam logic [6:0] ADDR_FALLBACK = 7'h67;
  localparam logic [6:0] ADDR_NORMAL   = 7'h68;

  // ==========================================
  // Reset values
  localparam logic SSC_PIN_RESET = 1'b1;

  // ==========================================
  // Types
  typedef enum logic [1:0] {
    MODE_NONE,
    MODE_FALLBACK,
    MODE_PIN,
    MODE_SERIAL
  } mode_t;

  typedef enum logic [1:0] {
    BOOT_WAIT,
    BOOT_SAMPLE,
    BOOT_RUN
  } boot_state_t;

  typedef enum logic [2:0] {
    FUNC_NONE,
    FUNC_LOCK,
    FUNC_STEP_UP,
    FUNC_STEP_DOWN,
    FUNC_GLOBAL_OE,
    FUNC_SSC
  } gpio_func_t;

  typedef struct packed {
    logic       global_power_down;
    logic [8:0] pll_block_pd;
    logic       channel_four_pd_bit;
    logic       channel_three_power_down;
    logic       channel_two_power_down;
    logic       channel_one_power_down;
  } pd_ctrl_t;

  typedef struct packed {
    logic [8:0] pll_block_pd;
    logic [3:0] channel_pd;
    logic       bypass_pd;
  } pd_out_t;

  typedef struct packed {
    logic [3:0] drive;
    logic [3:0] oe_n;
  } gpio_pins_t;

endpackage : clockgen_pkg

`default_nettype wire
